// *** hw/lan_pres_pkg.sv ***
// Constants, types and helpers for the presentation header filter
// Function
// - Frames carry seven header fields plus payload
// - Version field is three bits, value 001
// - Reserved control bit always built as zero
// - Key index: 0 clear, 1-14 key, 15 change
// - Drop received frames with foreign key index
// - Accept install probe traffic with key zero
// - Accept key fifteen download and key-write
// - Uplink network id from configured parameter
// - Drop downlink frames with other network id
// - Format applies to all non-download frames
// - Counter MSB first, separate data/probe counters
// - Timestamp is epoch low two bytes, MSB first
// - Access signature spans control through timestamp
// - Application selector names the payload layer
package lan_pres_pkg;

  localparam logic [2:0]  VERSION_V1   = 3'h1;
  localparam logic [3:0]  KEY_CLEAR    = 4'h0;
  localparam logic [3:0]  KEY_CHANGE   = 4'hF;
  localparam int          HDR_BYTES    = 5;
  localparam int          TRL_BYTES    = 8;
  localparam int          FIFO_DEPTH   = 32;

  // Register byte offsets
  localparam logic [7:0]  CFG_OFS      = 8'h00;
  localparam logic [7:0]  EPOCH_OFS    = 8'h04;
  localparam logic [7:0]  SEL_OFS      = 8'h08;
  localparam logic [7:0]  TXCNT_OFS    = 8'h0C;
  localparam logic [7:0]  RXCNT_OFS    = 8'h10;

  // Reset values
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;
  localparam logic [31:0] EPOCH_RST    = 32'h0000_0000;
  localparam logic [31:0] SEL_RST      = 32'h0000_0000;
  localparam logic [15:0] CNT_RST      = 16'h0000;

  // Field positions in the configuration words
  localparam int          CFG_KEY_LSB  = 0;
  localparam int          CFG_NET_LSB  = 8;
  localparam int          CFG_APP_LSB  = 16;
  localparam int          SEL_INST_LSB = 0;
  localparam int          SEL_ADM_LSB  = 8;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HDR  = 2'b01,
    TX_PAY  = 2'b10,
    TX_TRL  = 2'b11
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_HDR  = 2'b00,
    RX_EMIT = 2'b01,
    RX_PASS = 2'b10,
    RX_DROP = 2'b11
  } rx_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } byte_s;

  typedef struct packed {
    logic        probe;
    logic [31:0] e2e_sig;
    logic [15:0] access_sig;
  } tx_desc_s;

  function automatic logic [7:0] ctrl_byte(input logic [3:0] key);
    ctrl_byte = {VERSION_V1, 1'b0, key};
  endfunction

  function automatic logic [7:0] pick_byte(input logic [63:0] w,
                                           input logic [2:0] i);
    pick_byte = w[(7 - i) * 8 +: 8];
  endfunction

endpackage

// *** hw/byte_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule // byte_fifo

// *** hw/lan_presentation_header_filter.sv ***
// Presentation header builder (uplink) and filter (downlink)
`timescale 1ns/1ps
module lan_presentation_header_filter
  import lan_pres_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Uplink frame descriptor
  input  wire tx_desc_s    tx_desc,
  input  wire logic        tx_desc_valid,
  output logic             tx_desc_ready,
  // Uplink payload from application
  input  wire byte_s       tx_pay,
  input  wire logic        tx_pay_valid,
  output logic             tx_pay_ready,
  // Uplink bytes to link layer
  output byte_s            tx_out,
  output logic             tx_out_valid,
  input  wire logic        tx_out_ready,
  // Downlink bytes from link layer
  input  wire byte_s       rx_in,
  input  wire logic        rx_in_valid,
  output logic             rx_in_ready,
  // Accepted downlink frames to application
  output byte_s            rx_out,
  output logic             rx_out_valid,
  input  wire logic        rx_out_ready
);

  // Registers
  logic [31:0] cfg_r;
  logic [31:0] epoch_r;
  logic [31:0] sel_r;
  logic [15:0] data_cnt_r;
  logic [15:0] probe_cnt_r;
  logic [15:0] acc_cnt_r;
  logic [15:0] drop_cnt_r;
  logic [3:0]  key_cfg;
  logic [7:0]  net_cfg;
  logic [7:0]  app_cfg;

  assign key_cfg = cfg_r[CFG_KEY_LSB +: 4];
  assign net_cfg = cfg_r[CFG_NET_LSB +: 8];
  assign app_cfg = cfg_r[CFG_APP_LSB +: 8];

  // AXI4-Lite write channel
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        wr_hit;

  assign s_awready = !aw_have_r && !s_bvalid;
  assign s_wready  = !w_have_r && !s_bvalid;
  assign wr_go     = aw_have_r && w_have_r && !s_bvalid;
  assign wr_hit    = aw_addr_r == CFG_OFS || aw_addr_r == EPOCH_OFS
                     || aw_addr_r == SEL_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_awaddr[7:2], 2'b00};
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r   <= CFG_RST;
      epoch_r <= EPOCH_RST;
      sel_r   <= SEL_RST;
    end else if (wr_go) begin
      case (aw_addr_r)
        CFG_OFS:   cfg_r   <= merge(cfg_r, w_data_r, w_strb_r);
        EPOCH_OFS: epoch_r <= merge(epoch_r, w_data_r, w_strb_r);
        SEL_OFS:   sel_r   <= merge(sel_r, w_data_r, w_strb_r);
        default:   ;
      endcase
    end
  end

  // AXI4-Lite read channel, answer one cycle after the address
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= RESP_OKAY;
      case ({s_araddr[7:2], 2'b00})
        CFG_OFS:   s_rdata <= cfg_r;
        EPOCH_OFS: s_rdata <= epoch_r;
        SEL_OFS:   s_rdata <= sel_r;
        TXCNT_OFS: s_rdata <= {probe_cnt_r, data_cnt_r};
        RXCNT_OFS: s_rdata <= {drop_cnt_r, acc_cnt_r};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // Uplink framing; the caller supplies both signatures, since the
  // ciphers live outside this block
  tx_state_e   tx_st_r;
  logic [2:0]  tx_idx_r;
  tx_desc_s    desc_r;
  logic [39:0] hdr_r;
  logic [15:0] tstamp_r;
  logic        load;
  logic        start;

  assign load          = !tx_out_valid || tx_out_ready;
  assign tx_desc_ready = tx_st_r == TX_IDLE;
  assign start         = tx_desc_valid && tx_desc_ready;
  assign tx_pay_ready  = tx_st_r == TX_PAY && load;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_r      <= TX_IDLE;
      tx_idx_r     <= 3'h0;
      desc_r       <= '0;
      hdr_r        <= '0;
      tstamp_r     <= 16'h0000;
      tx_out       <= '0;
      tx_out_valid <= 1'b0;
    end else begin
      if (tx_out_valid && tx_out_ready) begin
        tx_out_valid <= 1'b0;
      end
      case (tx_st_r)
        TX_IDLE: begin
          if (start) begin
            desc_r   <= tx_desc;
            tstamp_r <= epoch_r[15:0];
            hdr_r    <= {ctrl_byte(key_cfg), net_cfg,
                         tx_desc.probe ? probe_cnt_r : data_cnt_r,
                         app_cfg};
            tx_idx_r <= 3'h0;
            tx_st_r  <= TX_HDR;
          end
        end
        TX_HDR: begin
          if (load) begin
            tx_out       <= '{data: pick_byte({hdr_r, 24'h0}, tx_idx_r),
                              last: 1'b0};
            tx_out_valid <= 1'b1;
            tx_idx_r     <= tx_idx_r + 3'h1;
            if (tx_idx_r == 3'(HDR_BYTES - 1)) begin
              tx_st_r <= TX_PAY;
            end
          end
        end
        TX_PAY: begin
          if (load && tx_pay_valid) begin
            tx_out       <= '{data: tx_pay.data, last: 1'b0};
            tx_out_valid <= 1'b1;
            if (tx_pay.last) begin
              tx_idx_r <= 3'h0;
              tx_st_r  <= TX_TRL;
            end
          end
        end
        TX_TRL: begin
          if (load) begin
            // Trailer MSB first: signature, timestamp, access signature
            tx_out <= '{data: pick_byte({desc_r.e2e_sig, tstamp_r,
                                         desc_r.access_sig}, tx_idx_r),
                        last: tx_idx_r == 3'(TRL_BYTES - 1)};
            tx_out_valid <= 1'b1;
            tx_idx_r     <= tx_idx_r + 3'h1;
            if (tx_idx_r == 3'(TRL_BYTES - 1)) begin
              tx_st_r <= TX_IDLE;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // One counter per flow, bumped as each new frame starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_cnt_r  <= CNT_RST;
      probe_cnt_r <= CNT_RST;
    end else if (start) begin
      if (tx_desc.probe) begin
        probe_cnt_r <= probe_cnt_r + 16'h0001;
      end else begin
        data_cnt_r <= data_cnt_r + 16'h0001;
      end
    end
  end

  // Downlink filter; header is held back until the verdict is known
  rx_state_e   rx_st_r;
  logic [2:0]  rx_idx_r;
  logic [39:0] rx_hdr_r;
  logic        fifo_in_ready;
  logic        fifo_in_valid;
  byte_s       fifo_in;
  logic        rx_take;
  logic        accept;
  logic [3:0]  rx_key;
  logic [7:0]  rx_app;

  // Four bytes in: control byte sits at [31:24], network id at [23:16]
  assign rx_key  = rx_hdr_r[27:24];
  assign rx_app  = rx_in.data;
  assign rx_take = rx_in_valid && rx_in_ready;

  // Verdict on the fifth header byte, with earlier bytes registered
  always_comb begin
    accept = rx_hdr_r[31:29] == VERSION_V1 && rx_key <= KEY_CHANGE;
    if (rx_hdr_r[23:16] != net_cfg) begin
      accept = 1'b0;
    end else if (rx_key == key_cfg) begin
      accept = 1'b1;
    end else if (rx_key == KEY_CLEAR) begin
      accept = rx_app == sel_r[SEL_INST_LSB +: 8];
    end else if (rx_key == KEY_CHANGE) begin
      accept = rx_app == sel_r[SEL_ADM_LSB +: 8];
    end else begin
      accept = 1'b0;
    end
    if (rx_hdr_r[31:29] != VERSION_V1) begin
      accept = 1'b0;
    end
  end

  always_comb begin
    case (rx_st_r)
      RX_HDR:  rx_in_ready = 1'b1;
      RX_EMIT: rx_in_ready = 1'b0;
      RX_PASS: rx_in_ready = fifo_in_ready;
      RX_DROP: rx_in_ready = 1'b1;
      default: rx_in_ready = 1'b0;
    endcase
  end

  assign fifo_in_valid = rx_st_r == RX_EMIT
                         || (rx_st_r == RX_PASS && rx_in_valid);
  assign fifo_in = rx_st_r == RX_EMIT
                   ? '{data: pick_byte({rx_hdr_r, 24'h0}, rx_idx_r),
                       last: 1'b0}
                   : rx_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r    <= RX_HDR;
      rx_idx_r   <= 3'h0;
      rx_hdr_r   <= '0;
      acc_cnt_r  <= CNT_RST;
      drop_cnt_r <= CNT_RST;
    end else begin
      case (rx_st_r)
        RX_HDR: begin
          if (rx_take) begin
            rx_hdr_r <= {rx_hdr_r[31:0], rx_in.data};
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_in.last) begin
              // Ends within the five header bytes, so no payload follows
              rx_idx_r   <= 3'h0;
              drop_cnt_r <= drop_cnt_r + 16'h0001;
            end else if (rx_idx_r == 3'(HDR_BYTES - 1)) begin
              rx_idx_r <= 3'h0;
              if (accept) begin
                rx_st_r   <= RX_EMIT;
                acc_cnt_r <= acc_cnt_r + 16'h0001;
              end else begin
                rx_st_r    <= RX_DROP;
                drop_cnt_r <= drop_cnt_r + 16'h0001;
              end
            end
          end
        end
        RX_EMIT: begin
          if (fifo_in_ready) begin
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == 3'(HDR_BYTES - 1)) begin
              rx_idx_r <= 3'h0;
              rx_st_r  <= RX_PASS;
            end
          end
        end
        RX_PASS, RX_DROP: begin
          if (rx_take && rx_in.last) begin
            rx_st_r <= RX_HDR;
          end
        end
        default: rx_st_r <= RX_HDR;
      endcase
    end
  end

  byte_fifo #(
    .WIDTH ($bits(byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (fifo_in),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_out),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready)
  );

endmodule // lan_presentation_header_filter

// *** sim/lan_hdr_sva.sv ***
// Port assertions for the presentation header filter
`timescale 1ns/1ps
module lan_hdr_sva
  import lan_pres_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  // Streams
  input wire logic        tx_desc_valid,
  input wire logic        tx_desc_ready,
  input wire byte_s       tx_out,
  input wire logic        tx_out_valid,
  input wire logic        tx_out_ready,
  input wire byte_s       rx_out,
  input wire logic        rx_out_valid,
  input wire logic        rx_out_ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence desc_take;
    tx_desc_valid && tx_desc_ready;
  endsequence
  sequence ctrl_first;
    ##2 tx_out_valid && tx_out.data[7:4] == 4'h2 && !tx_out.last;
  endsequence

  wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid &&
    s_wready |=> !s_awready ##1 s_bvalid) else $error("write answer late");
  wr_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write answer dropped");
  rd_answer_a: assert property (s_arvalid && s_arready |=>
    s_rvalid && !s_arready) else $error("read answer late");
  rd_hold_a: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata)) else $error("read data moved");
  up_ctrl_a: assert property (desc_take |-> ctrl_first)
    else $error("control byte wrong");
  up_busy_a: assert property (desc_take |=> (!tx_desc_ready) [*3])
    else $error("descriptor taken mid frame");
  up_hold_a: assert property (tx_out_valid && !tx_out_ready |=>
    tx_out_valid && $stable(tx_out)) else $error("uplink byte moved");
  dn_hold_a: assert property (rx_out_valid && !rx_out_ready |=>
    rx_out_valid && $stable(rx_out)) else $error("downlink byte moved");
endmodule // lan_hdr_sva

bind lan_presentation_header_filter lan_hdr_sva chk_u (.aclk, .aresetn,
  .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready,
  .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .tx_desc_valid,
  .tx_desc_ready, .tx_out, .tx_out_valid, .tx_out_ready, .rx_out,
  .rx_out_valid, .rx_out_ready);

// *** sim/link_partner.sv ***
// Link-layer model: takes uplink bytes, offers downlink bytes
`timescale 1ns/1ps
module link_partner
  import lan_pres_pkg::*;
(
  // Clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Pacing
  input  wire logic  slow,
  // Uplink bytes
  input  wire byte_s tx_out,
  input  wire logic  tx_out_valid,
  output logic       tx_out_ready,
  // Downlink bytes
  output byte_s      rx_in,
  output logic       rx_in_valid,
  input  wire logic  rx_in_ready
);
  byte_s rxq[$];
  byte_s txq[$];
  logic  tick_r;

  // Frames kept whole and in order on both directions
  always @(posedge aclk) begin
    tick_r <= aresetn && !tick_r;
    tx_out_ready <= aresetn && !(slow && tick_r);
    if (tx_out_valid && tx_out_ready) begin
      txq.push_back(tx_out);
    end
    if (!aresetn) begin
      rx_in <= '0;
      rx_in_valid <= 1'b0;
    end else if (!rx_in_valid || rx_in_ready) begin
      if (rxq.size() != 0 && !(slow && tick_r)) begin
        rx_in <= rxq.pop_front();
        rx_in_valid <= 1'b1;
      end else begin
        // Released line shows junk, not the last byte
        rx_in <= ~rx_in;
        rx_in_valid <= 1'b0;
      end
    end
  end
endmodule // link_partner

// *** sim/lan_presentation_header_filter_tb.sv ***
// Testbench for the presentation header filter
`timescale 1ns/1ps
module lan_presentation_header_filter_tb
  import lan_pres_pkg::*;
;
  logic        aclk, aresetn, slow;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  tx_desc_s    tx_desc;
  logic        tx_desc_valid, tx_desc_ready;
  byte_s       tx_pay, tx_out, rx_in, rx_out;
  logic        tx_pay_valid, tx_pay_ready, tx_out_valid, tx_out_ready;
  logic        rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  byte_s       exp_up[$], exp_dn[$], got_dn[$];
  int          n_errors, num_checks, total;

  lan_presentation_header_filter dut_u (.aclk, .aresetn, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .tx_desc, .tx_desc_valid,
    .tx_desc_ready, .tx_pay, .tx_pay_valid, .tx_pay_ready, .tx_out,
    .tx_out_valid, .tx_out_ready, .rx_in, .rx_in_valid, .rx_in_ready,
    .rx_out, .rx_out_valid, .rx_out_ready);
  link_partner p_u (.aclk, .aresetn, .slow, .tx_out, .tx_out_valid,
    .tx_out_ready, .rx_in, .rx_in_valid, .rx_in_ready);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (rx_out_valid && rx_out_ready) got_dn.push_back(rx_out);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_bvalid);
    chk(s_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    chk(s_rdata, ed);
    chk(s_rresp, er);
  endtask

  // Uplink frame with key 3, net 5A, app 21, epoch low ABCD
  task automatic up(input logic pr, input int np, input logic [15:0] cnt);
    logic [39:0] hd;
    logic [63:0] tr;
    hd = {8'h23, 8'h5A, cnt, 8'h21};
    tr = {32'hDEAD_BEEF, 16'hABCD, 16'h55AA};
    for (int i = 0; i < 5; i++) exp_up.push_back({hd[39-8*i -: 8], 1'b0});
    for (int i = 0; i < np; i++) exp_up.push_back({8'hA0 + 8'(i), 1'b0});
    for (int i = 0; i < 8; i++) exp_up.push_back({tr[63-8*i -: 8], i == 7});
    tx_desc <= '{probe: pr, e2e_sig: 32'hDEAD_BEEF, access_sig: 16'h55AA};
    tx_desc_valid <= 1'b1;
    do @(posedge aclk); while (!tx_desc_ready);
    tx_desc_valid <= 1'b0;
    for (int i = 0; i < np; i++) begin
      tx_pay <= '{data: 8'hA0 + 8'(i), last: i == np - 1};
      tx_pay_valid <= 1'b1;
      do @(posedge aclk); while (!tx_pay_ready);
    end
    tx_pay_valid <= 1'b0;
  endtask

  task automatic dn(input logic [7:0] c, n, app, input int np, input bit ok);
    logic [39:0] hd;
    byte_s       b;
    hd = {c, n, 16'h0007, app};
    for (int i = 0; i < 5 + np; i++) begin
      b = (i < 5) ? {hd[39-8*i -: 8], 1'b0} : {8'h30 + 8'(i), i == np + 4};
      p_u.rxq.push_back(b);
      if (ok) exp_dn.push_back(b);
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim;
  end

  initial begin
    {aresetn, slow, s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {tx_desc, tx_desc_valid, tx_pay, tx_pay_valid, rx_out_ready} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CFG_OFS, CFG_RST, RESP_OKAY);
    rd(SEL_OFS, SEL_RST, RESP_OKAY);
    wr(CFG_OFS, 32'h0021_5A03, RESP_OKAY);
    wr(SEL_OFS, 32'h0000_2211, RESP_OKAY);
    wr(EPOCH_OFS, 32'h1234_ABCD, RESP_OKAY);
    wr(TXCNT_OFS, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
    rd(CFG_OFS, 32'h0021_5A03, RESP_OKAY);
    up(1'b0, 2, 16'h0000);
    slow <= 1'b1;
    up(1'b0, 1, 16'h0001);
    up(1'b1, 3, 16'h0000);
    while (p_u.txq.size() < exp_up.size()) @(posedge aclk);
    foreach (exp_up[i]) chk(p_u.txq[i], exp_up[i]);
    rd(TXCNT_OFS, 32'h0001_0002, RESP_OKAY);
    // Queue off the edge so the partner cannot pop before the count
    @(negedge aclk);
    // Application side stalls so the FIFO fills and refuses
    dn(8'h23, 8'h5A, 8'h21, 40, 1);
    dn(8'h25, 8'h5A, 8'h21, 3, 0);
    dn(8'h20, 8'h5A, 8'h11, 2, 1);
    dn(8'h20, 8'h5A, 8'h21, 2, 0);
    dn(8'h2F, 8'h5A, 8'h22, 2, 1);
    dn(8'h23, 8'h5B, 8'h21, 2, 0);
    dn(8'h43, 8'h5A, 8'h21, 2, 0);
    total = p_u.rxq.size();
    while (p_u.rxq.size() > total - 33) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk(rx_in_ready, 1'b0);
    rx_out_ready <= 1'b1;
    while (p_u.rxq.size() != 0 || rx_in_valid ||
           got_dn.size() < exp_dn.size()) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk(got_dn.size(), exp_dn.size());
    foreach (exp_dn[i]) chk(got_dn[i], exp_dn[i]);
    rd(RXCNT_OFS, 32'h0004_0003, RESP_OKAY);
    end_sim;
  end
endmodule // lan_presentation_header_filter_tb
